//--- src/vic_top.sv
// vic_top: normal and fast interrupt masking, programmed interrupts and
// the vectored extension (base, readback, priority banks 0 and 1).
// assumes: peripheral request levels are synchronous to hclk and held
// until the peripheral is serviced; ahb-lite master of single words.
//
// Behaviour
// R1: fast mask clear clears only written ones
// R2: software clears enables only when source quiet
// R3: fast pending is raw and enable; requests core
// R4: no vector without the vectored extension
// R5: programmed interrupts bypass enable masks
// R6: control bit 2 drives fast bit 1
// R7: control bit 1 drives normal bit 1
// R8: sources hold requests for the latency time
// R9: nesting bits 0/1 enable vectoring per path; here only bit 0 acts, bit 1 is stored only
// R10: eight levels per path, fast over normal; here levels exist on the normal path only
// R11: three-bit level 0..7 per source; here only sources 1..15 have a field, the others sit at level 7
// R12: sixteen-bit vector base, upper bits zero
// R13: readback holds base, top index, zeros
// R14: reported index equals status bit position
// R15: software reads readback only when vectoring
// R16: priority bank 0 field layout
// R17: priority bank 1 field layout
// R18: or of fast bits 31..1 drives line, bit 0
// R19: a source is never enabled on both paths
// R20: normal pending is raw and enable; or drives line
// R21: reserved bits read zero; read-only ignore writes
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module vic_top #(
  parameter int unsigned NUM_SRC = 32 // sources in each status word
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  input  wire logic [NUM_SRC-1:0] source_req,
  output logic                    normal_irq,
  output logic                    fast_irq
);
  // register file state
  logic [NUM_SRC-1:0]          normal_enable_mask; // normal enables
  logic [NUM_SRC-1:0]          fast_enable_mask;   // fast enables
  logic [31:0]                 software_interrupt_control;
  logic [31:0]                 nesting_control;    // vectoring enables
  logic [vic_pkg::BASE_W-1:0]  vector_table_base;  // table base
  logic [31:0]                 source_priority_bank0;
  logic [31:0]                 source_priority_bank1;

  // derived status words
  logic [NUM_SRC-1:0] normal_raw_source;     // raw normal view
  logic [NUM_SRC-1:0] fast_raw_source;       // raw fast view
  logic [NUM_SRC-1:0] normal_pending_status; // enabled normal
  logic [NUM_SRC-1:0] fast_pending_status;   // enabled fast
  logic               fast_any;              // any fast request

  // vector path
  logic [3*vic_pkg::VEC_SOURCES-1:0] levels;   // level per source
  logic                              top_found; // some normal source 0..27 pending
  logic [vic_pkg::IDX_W-1:0]         top_index; // encoder result
  logic [vic_pkg::IDX_W-1:0]         vec_index; // index shown
  logic [31:0]                       normal_vector_readback;

  // bus side
  logic [31:0] wdata;   // write data of the strobe
  logic        wr;      // write strobe
  logic [31:0] waddr;   // write address
  logic [31:0] rd_word; // read mux result

  // strobes from the bus slave
  vic_regs_if rif ();

  // bus protocol handled apart from the register file
  vic_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .rif       (rif)
  );

  // write strobe, address, data
  assign wr    = rif.wr_en;
  assign waddr = rif.wr_addr;
  assign wdata = rif.wr_data;

  // raw views: bit 0 is the fast summary, bit 1 the programmed source
  // other bits pass through
  always_comb begin
    normal_raw_source = source_req;
    fast_raw_source   = source_req;
    // summary of fast requests on both paths, see R18
    normal_raw_source[vic_pkg::SRC_FAST_ANY] = fast_any;
    fast_raw_source[vic_pkg::SRC_FAST_ANY]   = fast_any;
    // programmed bits written straight into raw views, see R5
    normal_raw_source[vic_pkg::SRC_SOFT] =
      software_interrupt_control[vic_pkg::SWI_IRQ_BIT]; // see R7
    fast_raw_source[vic_pkg::SRC_SOFT] =
      software_interrupt_control[vic_pkg::SWI_FIQ_BIT]; // see R6
  end

  // fast summary from bits 31..1 only, so bit 0 cannot feed itself
  // source bits 1:0 are internal
  assign fast_any = |(source_req[NUM_SRC-1:2] & fast_enable_mask[NUM_SRC-1:2])
                  | software_interrupt_control[vic_pkg::SWI_FIQ_BIT]; // see R18

  // pending views: raw and enable, programmed bit unmasked
  // bit 1 handled apart, and bit 0 on the fast path
  always_comb begin
    normal_pending_status = normal_raw_source & normal_enable_mask; // see R20
    fast_pending_status   = fast_raw_source & fast_enable_mask; // see R3
    // programmed interrupts are not maskable, see R5
    normal_pending_status[vic_pkg::SRC_SOFT] =
      normal_raw_source[vic_pkg::SRC_SOFT]; // see R7
    fast_pending_status[vic_pkg::SRC_SOFT] =
      fast_raw_source[vic_pkg::SRC_SOFT]; // see R6
    // fast summary bit needs no enable on the fast path
    fast_pending_status[vic_pkg::SRC_FAST_ANY] = fast_any; // see R18
  end

  // core exception lines
  // both are plain levels
  assign fast_irq   = fast_any; // see R3 R18
  assign normal_irq = |normal_pending_status; // see R20

  // normal enables: write ones to set, clear word to drop
  // setting a normal enable drops the fast one of the same source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      normal_enable_mask <= '0;
    end else if (wr) begin
      if (waddr == vic_pkg::ADDR_NORMAL_ENABLE) begin
        // ones set, zeros keep
        normal_enable_mask <= normal_enable_mask | wdata[NUM_SRC-1:0];
      end else if (waddr == vic_pkg::ADDR_NORMAL_CLEAR) begin
        // written ones drop
        normal_enable_mask <= normal_enable_mask & ~wdata[NUM_SRC-1:0];
      end else if (waddr == vic_pkg::ADDR_FAST_ENABLE) begin
        // fast set removes the normal twin, see R19
        normal_enable_mask <= normal_enable_mask & ~wdata[NUM_SRC-1:0];
      end
    end
  end

  // fast enables: same scheme, mirrored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_enable_mask <= '0;
    end else if (wr) begin
      if (waddr == vic_pkg::ADDR_FAST_ENABLE) begin
        // ones set, zeros keep
        fast_enable_mask <= fast_enable_mask | wdata[NUM_SRC-1:0];
      end else if (waddr == vic_pkg::ADDR_FAST_CLEAR) begin
        // only written ones drop, no read-modify-write, see R1
        fast_enable_mask <= fast_enable_mask & ~wdata[NUM_SRC-1:0];
      end else if (waddr == vic_pkg::ADDR_NORMAL_ENABLE) begin
        // normal set removes the fast twin, see R19
        fast_enable_mask <= fast_enable_mask & ~wdata[NUM_SRC-1:0];
      end
    end
  end

  // programmed interrupt control; only bits 2 and 1 exist
  // reserved bits masked off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      software_interrupt_control <= vic_pkg::RST_WORD;
    end else if (wr && waddr == vic_pkg::ADDR_SWI_CTRL) begin
      software_interrupt_control <= wdata & vic_pkg::SWI_MASK; // see R6 R7 R21
    end
  end

  // per-path vectoring enables
  // bit 1 is stored only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nesting_control <= vic_pkg::RST_WORD;
    end else if (wr && waddr == vic_pkg::ADDR_NESTING) begin
      nesting_control <= wdata & vic_pkg::NEST_MASK; // see R9 R21
    end
  end

  // vector base, low sixteen bits only
  // upper half never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_table_base <= vic_pkg::RST_BASE;
    end else if (wr && waddr == vic_pkg::ADDR_VECTOR_BASE) begin
      vector_table_base <= wdata[vic_pkg::BASE_W-1:0]; // see R12
    end
  end

  // priority banks; reserved nibble bits never stored
  // one bank per write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_priority_bank0 <= vic_pkg::RST_WORD;
      source_priority_bank1 <= vic_pkg::RST_WORD;
    end else if (wr) begin
      if (waddr == vic_pkg::ADDR_PRIO_BANK0) begin
        // slot 0 has no field, see R16
        source_priority_bank0 <= wdata & vic_pkg::PRIO0_MASK; // see R21
      end
      if (waddr == vic_pkg::ADDR_PRIO_BANK1) begin
        source_priority_bank1 <= wdata & vic_pkg::PRIO1_MASK; // see R17
      end
    end
  end

  // level of each vectored source; slot n of a bank is source n (+8)
  // sources without a field here sit at the lowest level, a limitation
  // until the remaining banks are added
  always_comb begin
    levels = '0;
    for (int s = 0; s < vic_pkg::VEC_SOURCES; s++) begin
      if (s == 0) begin
        // source 0 cannot be prioritised
        levels[3*s +: 3] = vic_pkg::LEVEL_LOWEST;
      end else if (s < vic_pkg::SLOTS_BANK) begin
        // flash, timers and software source, see R16 R11
        levels[3*s +: 3] = vic_pkg::vic_field(source_priority_bank0, s);
      end else if (s < 2 * vic_pkg::SLOTS_BANK) begin
        // converter, serial ports, pll, serial buses, see R17 R11
        levels[3*s +: 3] = vic_pkg::vic_field(source_priority_bank1,
                                              s - vic_pkg::SLOTS_BANK);
      end else begin
        // banks 2 and 3 absent
        levels[3*s +: 3] = vic_pkg::LEVEL_LOWEST;
      end
    end
  end

  // eight levels on the normal path; fast path keeps its own line
  // so any fast request still outranks every normal one
  // ties favour the low index
  vic_prio_encoder #(
    .N (vic_pkg::VEC_SOURCES)
  ) u_normal_enc (
    .pending (normal_pending_status[vic_pkg::VEC_SOURCES-1:0]),
    .levels  (levels),
    .found   (top_found),
    .index   (top_index)
  ); // see R10 R14

  // no encoding reaches software unless normal vectoring is on
  // index zero when off
  always_comb begin
    vec_index = '0;
    if (nesting_control[vic_pkg::NEST_IRQ_BIT] && top_found) begin
      vec_index = top_index; // see R4 R9 R14
    end
  end

  // readback word: zeros, base, index, zeros
  // base lands in 22:7
  always_comb begin
    normal_vector_readback = vic_pkg::RST_WORD;
    normal_vector_readback[vic_pkg::VEC_BASE_LSB +: vic_pkg::BASE_W] =
      vector_table_base; // see R13
    normal_vector_readback[vic_pkg::VEC_IDX_LSB +: vic_pkg::IDX_W] =
      vec_index; // see R13
  end

  // read mux; unmapped and write-only words read zero
  always_comb begin
    rd_word = vic_pkg::RST_WORD;
    case (rif.rd_addr)
      vic_pkg::ADDR_NORMAL_STATUS: begin
        // masked normal view
        rd_word = 32'(normal_pending_status); // see R20
      end
      vic_pkg::ADDR_NORMAL_RAW: begin
        // unmasked levels
        rd_word = 32'(normal_raw_source);
      end
      vic_pkg::ADDR_NORMAL_ENABLE: begin
        // plain mask
        rd_word = 32'(normal_enable_mask);
      end
      vic_pkg::ADDR_SWI_CTRL: begin
        // bits 2:1 only
        rd_word = software_interrupt_control;
      end
      vic_pkg::ADDR_VECTOR_BASE: begin
        // upper half always zero, see R12
        rd_word = 32'(vector_table_base);
      end
      vic_pkg::ADDR_VECTOR_READ: begin
        // live index
        rd_word = normal_vector_readback; // see R13
      end
      vic_pkg::ADDR_PRIO_BANK0: begin
        // slot 0 empty
        rd_word = source_priority_bank0;
      end
      vic_pkg::ADDR_PRIO_BANK1: begin
        rd_word = source_priority_bank1;
      end
      vic_pkg::ADDR_NESTING: begin
        // bits 1:0 only
        rd_word = nesting_control;
      end
      vic_pkg::ADDR_FAST_STATUS: begin
        rd_word = 32'(fast_pending_status); // see R3
      end
      vic_pkg::ADDR_FAST_RAW: begin
        // unmasked levels
        rd_word = 32'(fast_raw_source);
      end
      vic_pkg::ADDR_FAST_ENABLE: begin
        // plain mask
        rd_word = 32'(fast_enable_mask);
      end
      default: begin
        // clear registers are write-only, see R21
        rd_word = vic_pkg::RST_WORD;
      end
    endcase
  end

  assign rif.rd_data = rd_word;

  // hsize carries no meaning here: every access is a whole word
  logic unused_size;
  assign unused_size = ^hsize;
endmodule : vic_top
`default_nettype wire

//--- shared/vic_pkg.sv
// vic_pkg: addresses, field positions, masks and reset values of the
// vectored interrupt controller.
// assumes: a 32-bit register bus with word-aligned byte addresses.
package vic_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_NORMAL_STATUS = 32'hffff0000;
  localparam logic [31:0] ADDR_NORMAL_RAW    = 32'hffff0004;
  localparam logic [31:0] ADDR_NORMAL_ENABLE = 32'hffff0008;
  localparam logic [31:0] ADDR_NORMAL_CLEAR  = 32'hffff000c;
  localparam logic [31:0] ADDR_SWI_CTRL      = 32'hffff0010;
  localparam logic [31:0] ADDR_VECTOR_BASE   = 32'hffff0014;
  localparam logic [31:0] ADDR_VECTOR_READ   = 32'hffff001c;
  localparam logic [31:0] ADDR_PRIO_BANK0    = 32'hffff0020;
  localparam logic [31:0] ADDR_PRIO_BANK1    = 32'hffff0024;
  localparam logic [31:0] ADDR_NESTING       = 32'hffff0030;
  localparam logic [31:0] ADDR_FAST_STATUS   = 32'hffff0100;
  localparam logic [31:0] ADDR_FAST_RAW      = 32'hffff0104;
  localparam logic [31:0] ADDR_FAST_ENABLE   = 32'hffff0108;
  localparam logic [31:0] ADDR_FAST_CLEAR    = 32'hffff010c;
  // bit positions
  localparam int unsigned SRC_FAST_ANY = 0;  // or of fast requests
  localparam int unsigned SRC_SOFT     = 1;  // programmed source
  localparam int unsigned SWI_IRQ_BIT  = 1;
  localparam int unsigned SWI_FIQ_BIT  = 2;
  localparam int unsigned NEST_IRQ_BIT = 0;
  localparam int unsigned NEST_FIQ_BIT = 1;
  // field widths and places in the vector word
  localparam int unsigned BASE_W       = 16;
  localparam int unsigned IDX_W        = 5;
  localparam int unsigned LEVEL_W      = 3;
  localparam int unsigned VEC_IDX_LSB  = 2;
  localparam int unsigned VEC_BASE_LSB = 7;
  localparam int unsigned VEC_SOURCES  = 28; // indices 0 to 27
  localparam int unsigned SLOTS_BANK   = 8;  // fields per bank
  // writable bits of each register
  localparam logic [31:0] PRIO0_MASK = 32'h77777770;
  localparam logic [31:0] PRIO1_MASK = 32'h77777777;
  localparam logic [31:0] SWI_MASK   = 32'h00000006;
  localparam logic [31:0] NEST_MASK  = 32'h00000003;
  // reset values
  localparam logic [31:0]  RST_WORD     = 32'h00000000;
  localparam logic [15:0]  RST_BASE     = 16'h0000;
  localparam logic [2:0]   LEVEL_LOWEST = 3'h7;

  // three-bit level field of one slot in a priority word
  function automatic logic [2:0] vic_field(input logic [31:0] w,
                                           input int unsigned slot);
    vic_field = w[4*slot +: 3];
  endfunction : vic_field
endpackage : vic_pkg

//--- shared/vic_regs_if.sv
// vic_regs_if: register access strobes between bus slave and register file.
// assumes: one write and one read address per cycle at most.
`timescale 1ns/1ps
`default_nettype none
interface vic_regs_if;
  logic        wr_en;   // one-cycle write strobe
  logic [31:0] wr_addr; // write byte address
  logic [31:0] wr_data; // write data
  logic [31:0] rd_addr; // read byte address
  logic [31:0] rd_data; // read data, combinational
  modport bus  (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport regs (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : vic_regs_if
`default_nettype wire

//--- src/vic_ahb_slave.sv
// vic_ahb_slave: ahb-lite slave front end, zero wait except one stall
// assumes: single slave, so hready equals this block's hreadyout.
`timescale 1ns/1ps
`default_nettype none
module vic_ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  vic_regs_if.bus          rif
);
  logic        wr_pend; // write data phase in progress
  logic [31:0] wr_addr; // latched write address
  logic        accept;  // valid address phase
  logic        stall;   // read behind a write
  logic        take;    // address phase taken

  // a read right behind a write waits one cycle so it sees the new value
  assign accept    = hsel & htrans[1] & hready;
  assign stall     = hsel & htrans[1] & ~hwrite & wr_pend; // hready term would loop
  assign take      = accept & ~stall;
  assign hreadyout = ~stall;
  assign hresp     = 1'b0; // always okay

  assign rif.wr_en   = wr_pend;
  assign rif.wr_addr = wr_addr;
  assign rif.wr_data = hwdata;
  assign rif.rd_addr = haddr;

  // write address capture; the write commits in its first data cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= vic_pkg::RST_WORD;
    end else begin
      wr_pend <= take & hwrite;
      if (take & hwrite) begin
        wr_addr <= haddr;
      end
    end
  end

  // read data sampled at address phase, shown in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= vic_pkg::RST_WORD;
    end else if (take & ~hwrite) begin
      hrdata <= rif.rd_data;
    end
  end
endmodule : vic_ahb_slave
`default_nettype wire

//--- src/vic_prio_encoder.sv
// vic_prio_encoder: picks the pending source of best level, 0 best.
// assumes: ties go to the lowest source index.
`timescale 1ns/1ps
`default_nettype none
module vic_prio_encoder #(
  parameter int unsigned N = 28
) (
  input  wire logic [N-1:0]                 pending,
  input  wire logic [3*N-1:0]               levels,
  output logic                              found,
  output logic [vic_pkg::IDX_W-1:0]         index
);
  logic [2:0] best; // best level so far

  // scan from the top so that a tie leaves the lowest index
  always_comb begin
    found = 1'b0;
    index = '0;
    best  = vic_pkg::LEVEL_LOWEST;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i] && (!found || levels[3*i +: 3] <= best)) begin
        found = 1'b1;
        best  = levels[3*i +: 3];
        index = vic_pkg::IDX_W'(i);
      end
    end
  end
endmodule : vic_prio_encoder
`default_nettype wire

//--- test/vic_asserts.sv
// vic_asserts: bus-visible properties of the interrupt controller top.
// assumes: one ahb-lite master, hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module vic_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        normal_irq,
  input wire logic        fast_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        rd_ph; // read data phase in progress
  logic [31:0] rd_a;  // address of that read
  logic        done;  // read data taken this edge
  // track the read data phase so hrdata can be tied to its address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph <= 1'b0;
      rd_a  <= 32'h0;
    end else if (hready) begin
      rd_ph <= hsel & htrans[1] & ~hwrite;
      rd_a  <= haddr;
    end
  end
  assign done = rd_ph & hready;
  base_hi_zero_a: assert property (done && rd_a == vic_pkg::ADDR_VECTOR_BASE
    |-> hrdata[31:16] == 16'h0) else $error("vector base upper bits set");
  vec_zero_a: assert property (done && rd_a == vic_pkg::ADDR_VECTOR_READ
    |-> hrdata[31:23] == 9'h0 && hrdata[1:0] == 2'h0) else $error("readback zero bits set");
  vec_idx_a: assert property (done && rd_a == vic_pkg::ADDR_VECTOR_READ
    |-> hrdata[6:2] < 5'd28) else $error("readback index out of range");
  prio0_resv_a: assert property (done && rd_a == vic_pkg::ADDR_PRIO_BANK0
    |-> (hrdata & ~vic_pkg::PRIO0_MASK) == 32'h0) else $error("bank0 reserved bits set");
  prio1_resv_a: assert property (done && rd_a == vic_pkg::ADDR_PRIO_BANK1
    |-> (hrdata & ~vic_pkg::PRIO1_MASK) == 32'h0) else $error("bank1 reserved bits set");
  swi_resv_a: assert property (done && rd_a == vic_pkg::ADDR_SWI_CTRL
    |-> (hrdata & ~vic_pkg::SWI_MASK) == 32'h0) else $error("control reserved bits set");
  clear_zero_a: assert property (done && rd_a == vic_pkg::ADDR_FAST_CLEAR
    |-> hrdata == 32'h0) else $error("mask clear reads nonzero");
  fast_sum_a: assert property (done && rd_a == vic_pkg::ADDR_FAST_STATUS
    |-> hrdata[0] == |hrdata[31:1]) else $error("fast summary bit wrong");
  fast_line_a: assert property (done && rd_a == vic_pkg::ADDR_FAST_STATUS
    |-> (|hrdata[31:1]) == $past(fast_irq)) else $error("fast line disagrees");
  normal_line_a: assert property (done && rd_a == vic_pkg::ADDR_NORMAL_STATUS
    |-> (|hrdata) == $past(normal_irq)) else $error("normal line disagrees");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
endmodule : vic_asserts
`default_nettype wire

//--- test/vic_source_model.sv
// vic_source_model: peripheral request levels facing the controller.
// assumes: the bench says which sources want service; bits 1:0 are internal.
`timescale 1ns/1ps
`default_nettype none
module vic_source_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [31:0] want,
  output logic      [31:0] source_req
);
  // levels are held for as long as wanted, never pulsed shorter than a cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_req <= 32'h0;
    end else begin
      source_req <= {want[31:2], 2'h0};
    end
  end
endmodule : vic_source_model
`default_nettype wire

//--- test/vectored_interrupt_controller_test.sv
// vectored_interrupt_controller_test: register-level tests of vic_top.
// assumes: single non-pipelined ahb-lite master, 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
bind vic_top vic_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hresp(hresp),
  .normal_irq(normal_irq), .fast_irq(fast_irq));
module vectored_interrupt_controller_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;  // word only
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] want = 32'h0;  // sources asking for service
  logic [31:0] hrdata;
  logic [31:0] source_req;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        normal_irq;
  logic        fast_irq;
  int          mismatches = 0;
  int          comparisons = 0;
  assign hready = hreadyout; // single slave
  always #5 hclk = ~hclk;
  vic_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .source_req(source_req),
    .normal_irq(normal_irq), .fast_irq(fast_irq));
  vic_source_model src_u (.hclk(hclk), .hresetn(hresetn), .want(want),
    .source_req(source_req));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one single transfer; entered and left just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rc
  task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    rc(a, e);
  endtask : wrc
  // sources change, then settle through the model's register
  task automatic srcs(input logic [31:0] v);
    want <= v;
    repeat (2) @(posedge hclk);
  endtask : srcs
  // irq lines looked at mid-cycle, away from the edge
  task automatic line(input logic f, input logic n);
    @(negedge hclk);
    chk({30'h0, fast_irq, normal_irq}, {30'h0, f, n});
    @(posedge hclk);
  endtask : line
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // hang guard, far beyond the roughly 160 cycles the tests need
  initial begin
    #200000;
    mismatches++;
    summarize;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(vic_pkg::ADDR_VECTOR_BASE, 32'h0);
    rc(vic_pkg::ADDR_VECTOR_READ, 32'h0);
    rc(vic_pkg::ADDR_PRIO_BANK0, 32'h0);
    rc(vic_pkg::ADDR_PRIO_BANK1, 32'h0);
    rc(vic_pkg::ADDR_FAST_STATUS, 32'h0);
    line(1'b0, 1'b0);
    // writable widths and reserved bits
    wrc(vic_pkg::ADDR_VECTOR_BASE, 32'hffffabcd, 32'h0000abcd);
    wrc(vic_pkg::ADDR_PRIO_BANK0, 32'hffffffff, 32'h77777770);
    wrc(vic_pkg::ADDR_PRIO_BANK1, 32'hffffffff, 32'h77777777);
    wrc(vic_pkg::ADDR_FAST_STATUS, 32'hffffffff, 32'h0);
    wrc(vic_pkg::ADDR_VECTOR_READ, 32'hffffffff, {9'h0, 16'habcd, 7'h0});
    wrc(32'hffff0200, 32'hffffffff, 32'h0);
    for (int l = 0; l < 8; l++) begin
      wrc(vic_pkg::ADDR_PRIO_BANK0, 32'(l) << 16, 32'(l) << 16);
    end
    // fast path masking, clearing and the exclusive enables
    srcs(32'h00000230);
    wr(vic_pkg::ADDR_FAST_ENABLE, 32'h00000230);
    rc(vic_pkg::ADDR_FAST_STATUS, 32'h00000231);
    rc(vic_pkg::ADDR_NORMAL_STATUS, 32'h0);
    line(1'b1, 1'b0);
    srcs(32'h00000210);
    wrc(vic_pkg::ADDR_FAST_CLEAR, 32'h00000020, 32'h0);
    rc(vic_pkg::ADDR_FAST_ENABLE, 32'h00000210);
    wr(vic_pkg::ADDR_NORMAL_ENABLE, 32'h00000200);
    rc(vic_pkg::ADDR_FAST_ENABLE, 32'h00000010);
    rc(vic_pkg::ADDR_NORMAL_STATUS, 32'h00000200);
    line(1'b1, 1'b1);
    srcs(32'h0);
    wr(vic_pkg::ADDR_FAST_CLEAR, 32'h00000010);
    wr(vic_pkg::ADDR_NORMAL_CLEAR, 32'h00000200);
    line(1'b0, 1'b0);
    // programmed requests bypass the masks
    wr(vic_pkg::ADDR_SWI_CTRL, 32'h00000004);
    rc(vic_pkg::ADDR_FAST_STATUS, 32'h00000003);
    rc(vic_pkg::ADDR_FAST_RAW, 32'h00000003);
    rc(vic_pkg::ADDR_NORMAL_RAW, 32'h00000001);
    line(1'b1, 1'b0);
    wr(vic_pkg::ADDR_SWI_CTRL, 32'h00000002);
    rc(vic_pkg::ADDR_NORMAL_STATUS, 32'h00000002);
    rc(vic_pkg::ADDR_NORMAL_RAW, 32'h00000002);
    line(1'b0, 1'b1);
    wrc(vic_pkg::ADDR_SWI_CTRL, 32'hffffffff, 32'h00000006);
    wr(vic_pkg::ADDR_SWI_CTRL, 32'h0);
    // vectoring: timer0 at level 3, timer2 at level 1
    wr(vic_pkg::ADDR_VECTOR_BASE, 32'h00001234);
    wr(vic_pkg::ADDR_PRIO_BANK0, 32'h00010300);
    wr(vic_pkg::ADDR_NORMAL_ENABLE, 32'h00000014);
    srcs(32'h00000014);
    rc(vic_pkg::ADDR_VECTOR_READ, {9'h0, 16'h1234, 7'h0});
    wr(vic_pkg::ADDR_NESTING, 32'h00000002);
    rc(vic_pkg::ADDR_VECTOR_READ, {9'h0, 16'h1234, 7'h0});
    wr(vic_pkg::ADDR_NESTING, 32'h00000001);
    rc(vic_pkg::ADDR_VECTOR_READ, {9'h0, 16'h1234, 5'h4, 2'h0});
    wr(vic_pkg::ADDR_PRIO_BANK0, 32'h00050300);
    rc(vic_pkg::ADDR_VECTOR_READ, {9'h0, 16'h1234, 5'h2, 2'h0});
    srcs(32'h0);
    wr(vic_pkg::ADDR_NORMAL_CLEAR, 32'h00000014);
    line(1'b0, 1'b0);
    summarize;
  end
endmodule : vectored_interrupt_controller_test
`default_nettype wire
